//--- design/dsf_pkg.sv
/*
 * Shared constants for the 24-bit SPI slave frame front end and its master.
 * Assumes a single 100 MHz system clock on both ends.
 */
package dsf_pkg;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int unsigned FRAME_BITS    = 24;
	localparam logic [7:0]  FRAME_CNT     = 8'h18;  // Clock count of a legal frame
	localparam logic [7:0]  ADDR_CNT      = 8'h08;  // Clocks until the address byte is in
	localparam int unsigned ADDR_MARK_POS = 23;     // Address byte MSB, must be one
	localparam int unsigned LAST_ADDRESS_BYTE_TOKEN_POS      = 22;     // Last address byte token
	localparam int unsigned SEL_MSB       = 21;     // Register selector A[4:0]
	localparam int unsigned SEL_LSB       = 17;
	localparam int unsigned OP_POS        = 16;     // Operation bit
	localparam logic [4:0]  STATUS_CLR_ADDR = 5'h10; // Clear here releases the reset bit

	// ----------------------------------------------------------------
	// Global status byte bit positions
	// ----------------------------------------------------------------
	localparam int unsigned ST_GEF  = 7;
	localparam int unsigned ST_FS   = 6;
	localparam int unsigned ST_TE   = 5;
	localparam int unsigned ST_POWER_ON_RESET_NEGATED_BIT = 4;
	localparam int unsigned ST_SUPPLY_ERROR_BIT = 3;
	localparam int unsigned ST_DRAIN_SOURCE_MONITOR_ERROR_BIT = 2;
	localparam int unsigned ST_OC   = 1;
	localparam int unsigned ST_PROTOCOL_ERROR_BIT = 0;
	localparam logic        POWER_ON_RESET_NEGATED_BIT_RST = 1'b0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ    = 100_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned THERM_FILT_US  = 10;
	localparam int unsigned THERM_FILT_CYC = THERM_FILT_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int unsigned SCLK_PERIOD_NS = 160;
	localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// Master APB register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_TX   = 12'h000;
	localparam logic [11:0] OFS_RX   = 12'h004;
	localparam logic [11:0] OFS_STAT = 12'h008;
	localparam int unsigned STAT_BUSY_POS = 0;
	localparam int unsigned STAT_GEF_POS  = 1;

	// ----------------------------------------------------------------
	// Master sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_LEAD = 6'h02,
		ST_HIGH = 6'h04,
		ST_LOW  = 6'h08,
		ST_LAG  = 6'h10,
		ST_GAP  = 6'h20
	} dsf_mst_state_t;

endpackage : dsf_pkg

//--- design/dsf_spi_if.sv
/*
 * Four-wire SPI link between the frame slave and the master.
 * Resolves the shared return line from the slave's low-active enable.
 */
`timescale 1ns/1ps
interface dsf_spi_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso_out;
	logic miso_oe_n;
	wire  miso;

	// Released return line reads as its pull-up level, never the last bit
	assign miso = miso_oe_n ? 1'b1 : miso_out;

	modport device (
		input  cs_n,
		input  sclk,
		input  mosi,
		output miso_out,
		output miso_oe_n
	);

	modport master (
		output cs_n,
		output sclk,
		output mosi,
		input  miso
	);
endinterface : dsf_spi_if

//--- design/dsf_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the inputs are asynchronous to clock_i.
 */
`timescale 1ns/1ps
module dsf_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clock_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] din_i,
	output logic      [W-1:0] level_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// Plain shift chain; stage one feeds stage two only
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= din_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			level_o <= RST_VAL;
		end else begin
			level_o <= (s2_q & s3_q) | (level_o & (s2_q ^ s3_q));
		end
	end
endmodule : dsf_sync

//--- design/dsf_device.sv
/*
 * Slave end of the 24-bit SPI frame: sampling, in-frame response,
 * global status byte, thermal filters and commit at chip-select release.
 * Assumes register storage lives outside: the selected word is read on
 * sel_data_i and writes or clears leave as a one-cycle strobe.
 */
`timescale 1ns/1ps
module dsf_device import dsf_pkg::*; #(
	parameter int unsigned FILT_CYC = THERM_FILT_CYC
) (
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	dsf_spi_if.device        spi,
	input  wire logic        fail_safe_i,
	input  wire logic        thermal_warning_i,
	input  wire logic        thermal_shutdown_i,
	input  wire logic        supply_uv_i,
	input  wire logic        supply_ov_i,
	input  wire logic        cp_uv_i,
	input  wire logic        vds_error_i,
	input  wire logic        overcurrent_i,
	output logic       [4:0]  sel_addr_o,
	input  wire logic [15:0] sel_data_i,
	output logic              wr_stb_o,
	output logic       [4:0]  wr_addr_o,
	output logic      [15:0] wr_data_o,
	output logic              wr_op_clear_o
);
	localparam int unsigned CW = $clog2(FILT_CYC + 1);

	// ----------------------------------------------------------------
	// Input conditioning
	// ----------------------------------------------------------------
	logic [4:0] lvl;
	logic [4:0] prev_q;
	logic       cs_n_l;
	logic       sclk_l;
	logic       mosi_l;
	logic [1:0] therm_raw;

	// Link pins and thermal comparators come from outside the clock domain
	// Reset levels match the idle pins so no false clock edge follows reset
	dsf_sync #(.W(5), .RST_VAL(5'h01)) u_sync (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.din_i   ({thermal_shutdown_i, thermal_warning_i, spi.mosi, spi.sclk, spi.cs_n}),
		.level_o (lvl)
	);

	assign cs_n_l    = lvl[0];
	assign sclk_l    = lvl[1];
	assign mosi_l    = lvl[2];
	assign therm_raw = lvl[4:3];

	// Previous filtered levels for edge finding
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			prev_q <= 5'h01;
		end else begin
			prev_q <= lvl;
		end
	end

	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic sclk_fall;

	// Clock edges only count inside a frame
	assign cs_fall   = prev_q[0] & ~cs_n_l;
	assign cs_rise   = ~prev_q[0] & cs_n_l;
	assign sclk_rise = ~prev_q[1] & sclk_l & ~cs_n_l;
	assign sclk_fall = prev_q[1] & ~sclk_l & ~cs_n_l;

	// ----------------------------------------------------------------
	// Thermal filters
	// ----------------------------------------------------------------
	logic [1:0] therm_q;

	// A level must hold for the full filter time before it is reported
	for (genvar g = 0; g < 2; g++) begin : g_filt
		logic [CW-1:0] cnt_q;
		always_ff @(posedge clock_i) begin
			if (srst_i) begin
				cnt_q      <= '0;
				therm_q[g] <= 1'b0;
			end else if (therm_raw[g] == therm_q[g]) begin
				cnt_q <= '0;
			end else if (cnt_q == CW'(FILT_CYC - 1)) begin
				cnt_q      <= '0;
				therm_q[g] <= therm_raw[g];
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Global status byte
	// ----------------------------------------------------------------
	logic       power_on_reset_negated_bit_q;
	logic       protocol_error_bit_q;
	logic [7:0] status;

	always_comb begin
		status          = 8'h00;
		status[ST_FS]   = fail_safe_i;
		status[ST_TE]   = therm_q[0] | therm_q[1];
		status[ST_POWER_ON_RESET_NEGATED_BIT] = power_on_reset_negated_bit_q;
		status[ST_SUPPLY_ERROR_BIT] = supply_uv_i | supply_ov_i | cp_uv_i;
		status[ST_DRAIN_SOURCE_MONITOR_ERROR_BIT] = vds_error_i;
		status[ST_OC]   = overcurrent_i;
		status[ST_PROTOCOL_ERROR_BIT] = protocol_error_bit_q;
		status[ST_GEF]  = |(status ^ (8'h01 << ST_POWER_ON_RESET_NEGATED_BIT));
	end

	// ----------------------------------------------------------------
	// Frame reception
	// ----------------------------------------------------------------
	logic [23:0] in_q;
	logic  [7:0] fall_cnt_q;
	logic  [7:0] rise_cnt_q;
	logic        pol_err_q;

	// Shift in on falling edges, MSB arrives first
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			in_q <= 24'h000000;
		end else if (sclk_fall) begin
			in_q <= {in_q[22:0], mosi_l};
		end
	end

	// Edge counters saturate so very long frames stay flagged
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fall_cnt_q <= 8'h00;
			rise_cnt_q <= 8'h00;
		end else if (cs_fall) begin
			fall_cnt_q <= 8'h00;
			rise_cnt_q <= 8'h00;
		end else begin
			if (sclk_fall && fall_cnt_q != 8'hFF) begin
				fall_cnt_q <= fall_cnt_q + 8'h01;
			end
			if (sclk_rise && rise_cnt_q != 8'hFF) begin
				rise_cnt_q <= rise_cnt_q + 8'h01;
			end
		end
	end

	// Clock seen high at either select edge is a polarity fault
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			pol_err_q <= 1'b0;
		end else if (cs_fall) begin
			pol_err_q <= sclk_l;
		end else if (cs_rise && sclk_l) begin
			pol_err_q <= 1'b1;
		end
	end

	// Selector is taken as soon as the address byte is complete
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			sel_addr_o <= 5'h00;
		end else if (sclk_fall && fall_cnt_q == ADDR_CNT - 8'h01) begin
			// Seven bits are in, so the selector sits seventeen places lower
			sel_addr_o <= in_q[SEL_MSB-FRAME_BITS+7:SEL_LSB-FRAME_BITS+7];
		end
	end

	// ----------------------------------------------------------------
	// Serial output
	// ----------------------------------------------------------------
	logic  [7:0] snap_q;
	logic [15:0] resp_q;
	logic        miso_q;
	logic  [4:0] rc;

	assign rc = rise_cnt_q[4:0];

	// Response is latched at the first rising edge after the address byte
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			resp_q <= 16'h0000;
		end else if (sclk_rise && rise_cnt_q == ADDR_CNT) begin
			resp_q <= sel_data_i;
		end
	end

	// Status is frozen at select fall so the flag and byte agree
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			snap_q <= 8'h00;
			miso_q <= 1'b0;
		end else if (cs_fall) begin
			snap_q <= status;
			miso_q <= status[ST_GEF];
		end else if (sclk_rise) begin
			if (rise_cnt_q < ADDR_CNT) begin
				miso_q <= snap_q[3'(5'h07 - rc)];
			end else if (rise_cnt_q == ADDR_CNT) begin
				miso_q <= sel_data_i[15];
			end else if (rise_cnt_q < FRAME_CNT) begin
				miso_q <= resp_q[4'(5'h17 - rc)];
			end else begin
				miso_q <= 1'b0;
			end
		end
	end

	assign spi.miso_out  = miso_q;
	assign spi.miso_oe_n = cs_n_l;

	// ----------------------------------------------------------------
	// Commit at select release
	// ----------------------------------------------------------------
	logic addr_ok;
	logic count_bad;
	logic frame_ok;
	logic frame_err;

	// Exactly 24 clocks, a proper address byte and no polarity fault make a frame good
	assign addr_ok   = in_q[ADDR_MARK_POS] & in_q[LAST_ADDRESS_BYTE_TOKEN_POS];
	assign count_bad = (fall_cnt_q != 8'h00) &&
	                   ((fall_cnt_q < FRAME_CNT) ||
	                    (fall_cnt_q > FRAME_CNT && fall_cnt_q[2:0] != 3'h0));
	assign frame_ok  = (fall_cnt_q == FRAME_CNT) && addr_ok && !pol_err_q;
	assign frame_err = count_bad || pol_err_q || (fall_cnt_q == FRAME_CNT && !addr_ok);

	// Writes leave only at the rising select edge, never mid-frame
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			wr_stb_o      <= 1'b0;
			wr_addr_o     <= 5'h00;
			wr_data_o     <= 16'h0000;
			wr_op_clear_o <= 1'b0;
		end else begin
			wr_stb_o <= cs_rise && frame_ok && in_q[OP_POS];
			if (cs_rise && frame_ok) begin
				wr_addr_o     <= in_q[SEL_MSB:SEL_LSB];
				wr_data_o     <= in_q[15:0];
				wr_op_clear_o <= in_q[OP_POS];
			end
		end
	end

	// Reset bit starts at zero and is released by a clear frame to STATUS_CLR_ADDR
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			power_on_reset_negated_bit_q <= POWER_ON_RESET_NEGATED_BIT_RST;
		end else if (cs_rise && frame_ok && in_q[OP_POS] &&
		             in_q[SEL_MSB:SEL_LSB] == STATUS_CLR_ADDR) begin
			power_on_reset_negated_bit_q <= 1'b1;
		end
	end

	// Protocol fault shows in the next frame; a good frame clears it
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			protocol_error_bit_q <= 1'b0;
		end else if (cs_rise && frame_err) begin
			protocol_error_bit_q <= 1'b1;
		end else if (cs_rise && frame_ok) begin
			protocol_error_bit_q <= 1'b0;
		end
	end
endmodule : dsf_device

//--- design/dsf_master.sv
/*
 * Master end of the 24-bit SPI frame, driven from an APB register port.
 * Assumes the slave end on the far side of the link interface.
 */
`timescale 1ns/1ps
module dsf_master import dsf_pkg::*; #(
	parameter int unsigned HALF_CYC = SCLK_HALF_CYC
) (
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	dsf_spi_if.master        spi,
	input  wire logic [11:0] paddr_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);
	localparam int unsigned DW = $clog2(HALF_CYC + 1);

	dsf_mst_state_t state_q;
	logic [DW-1:0]  div_q;
	logic  [4:0]    bit_q;
	logic [23:0]    tx_q;
	logic [23:0]    rx_q;
	logic           gef_q;
	logic           miso_l;
	logic           half_tick;
	logic           start;
	logic           busy;

	// ----------------------------------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------------------------------
	logic mapped;
	assign mapped    = (paddr_i == OFS_TX) || (paddr_i == OFS_RX) || (paddr_i == OFS_STAT);
	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign busy      = (state_q != ST_IDLE);
	assign start     = psel_i & penable_i & pwrite_i & (paddr_i == OFS_TX) & ~busy;

	// Read data is prepared in the setup cycle so it is ready at access
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			prdata_o <= 32'h00000000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			if (paddr_i == OFS_TX) begin
				prdata_o <= {8'h00, tx_q};
			end else if (paddr_i == OFS_RX) begin
				prdata_o <= {8'h00, rx_q};
			end else if (paddr_i == OFS_STAT) begin
				prdata_o <= {30'h0, gef_q, busy};
			end else begin
				prdata_o <= 32'h00000000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Link
	// ----------------------------------------------------------------
	dsf_sync #(.W(1), .RST_VAL(1'b0)) u_sync (
		.clock_i (clock_i),
		.srst_i  (srst_i),
		.din_i   (spi.miso),
		.level_o (miso_l)
	);

	// Half-period divider gives the serial clock phases
	assign half_tick = (div_q == DW'(HALF_CYC - 1));
	always_ff @(posedge clock_i) begin
		if (srst_i || !busy || half_tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// Writing TX while busy is ignored; the frame word is held
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			tx_q <= 24'h000000;
		end else if (start) begin
			tx_q <= pwdata_i[23:0];
		end
	end

	// Sequencer: clock idles low, data changes on rising, read before next rising
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state_q  <= ST_IDLE;
			spi.cs_n <= 1'b1;
			spi.sclk <= 1'b0;
			spi.mosi <= 1'b0;
			bit_q    <= 5'h00;
			rx_q     <= 24'h000000;
			gef_q    <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start) begin
						spi.cs_n <= 1'b0;
						spi.mosi <= pwdata_i[23];
						bit_q    <= 5'h00;
						state_q  <= ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (half_tick) begin
						spi.sclk <= 1'b1;
						state_q  <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (half_tick) begin
						// Round-trip sync lag: the pre-clock flag only arrives here
						if (bit_q == 5'h00) begin
							gef_q <= miso_l;
						end
						spi.sclk <= 1'b0;
						state_q  <= ST_LOW;
					end
				end
				ST_LOW: begin
					if (half_tick) begin
						rx_q  <= {rx_q[22:0], miso_l};
						bit_q <= bit_q + 5'h01;
						if (bit_q == 5'(FRAME_BITS - 1)) begin
							state_q <= ST_LAG;
						end else begin
							spi.sclk <= 1'b1;
							spi.mosi <= tx_q[5'(5'h16 - bit_q)];
							state_q  <= ST_HIGH;
						end
					end
				end
				ST_LAG: begin
					if (half_tick) begin
						spi.cs_n <= 1'b1;
						state_q  <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (half_tick) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end
endmodule : dsf_master

//--- verification/dsf_link_chk.sv
/*
 * Protocol checker for the serial link between the frame master and slave.
 * Assumes it watches the interface that joins the two design ends.
 */
`timescale 1ns/1ps
module dsf_link_chk (
	input  wire logic clock_i,
	input  wire logic srst_i,
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic mosi,
	input  wire logic miso_out,
	input  wire logic miso_oe_n
);
	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	logic [5:0] rise_q;
	logic [3:0] since_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	// Clock rises within the frame; cleared while deselected
	always_ff @(posedge clock_i) begin
		if (srst_i || cs_n) rise_q <= '0;
		else if ($rose(sclk)) rise_q <= rise_q + 6'h01;
	end

	// Cycles since the last event that may launch a return bit; saturates
	always_ff @(posedge clock_i) begin
		if (srst_i || $rose(sclk) || $fell(cs_n)) since_q <= '0;
		else if (since_q != 4'hF) since_q <= since_q + 4'h1;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	idle_clock_low_a: assert property (($fell(cs_n) || $rose(cs_n)) |-> !sclk && !$past(sclk))
		else $error("serial clock high at a select edge");
	select_gap_a: assert property ($rose(cs_n) |=> cs_n [*4])
		else $error("select gap too short");
	mosi_hold_a: assert property ($fell(sclk) |=> $stable(mosi) [*4])
		else $error("data changed while being sampled");
	drive_window_a: assert property (!cs_n && !miso_oe_n && $changed(miso_out) |-> since_q < 4'h8)
		else $error("return bit changed away from a rising edge");
	frame_count_a: assert property ($rose(cs_n) |-> rise_q == 6'h18)
		else $error("frame without 24 clocks");
	addr_mark_a: assert property ($fell(sclk) && rise_q == 6'h01 |-> mosi)
		else $error("address byte mark low");
	addr_token_a: assert property ($fell(sclk) && rise_q == 6'h02 |-> mosi)
		else $error("last address token low");
	flag_drive_a: assert property ($fell(cs_n) |-> ##[1:8] !miso_oe_n)
		else $error("return line not driven after select");
	frame_drive_a: assert property (!cs_n && !$past(cs_n, 8) |-> !miso_oe_n)
		else $error("return line released inside frame");
	idle_float_a: assert property (cs_n [*8] |-> miso_oe_n)
		else $error("return line driven while deselected");
endmodule : dsf_link_chk

//--- verification/driver_spi_slave_frame_tb.sv
/*
 * Self-checking bench: APB-driven master against a slave over one link,
 * and a bench-driven second link that breaks framing on purpose.
 * Assumes a 100 MHz clock and a scaled thermal filter of 20 cycles.
 */
`timescale 1ns/1ps
module driver_spi_slave_frame_tb import dsf_pkg::*; ;
	typedef struct {logic [23:0] tx; logic [7:0] flt; logic power_on_reset_negated_bit;} dsf_row_t;
	typedef struct {int nb; logic [31:0] w; logic pe; logic stb;} dsf_raw_t;
	logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rx, q;
	logic        pready, pslverr, stb1, stb2, wclr, e;
	logic [7:0]  flt = '0;
	logic [4:0]  sel1, sel2, wa;
	logic [15:0] wd;
	logic [24:0] r2;
	int          n_mismatch = 0, compares = 0, n_stb1 = 0, n_stb2 = 0, cyc = 0, n0;
	dsf_spi_if if1 ();
	dsf_spi_if if2 ();
	// Fault order: fail-safe, warn, shutdown, uv, ov, pump, drain, overcurrent
	dsf_row_t rows [8] = '{'{24'hE10000, 8'h00, 1'b0}, '{24'hC6ABCD, 8'h00, 1'b1},
		'{24'hD55A3C, 8'h00, 1'b1}, '{24'hD40000, 8'h80, 1'b1}, '{24'hFE0000, 8'h10, 1'b1},
		'{24'hC7FFFF, 8'h08, 1'b1}, '{24'hC90001, 8'h04, 1'b1}, '{24'hC10000, 8'h03, 1'b1}};
	dsf_raw_t raws [7] = '{'{12, 32'hC7123400, 1'b1, 1'b0}, '{28, 32'hC7123400, 1'b1, 1'b0},
		'{32, 32'hC7123400, 1'b0, 1'b0}, '{0, 32'hC7123400, 1'b0, 1'b0},
		'{24, 32'h47123400, 1'b1, 1'b0}, '{24, 32'h87123400, 1'b1, 1'b0},
		'{24, 32'hC7123400, 1'b0, 1'b1}};

	// ----------------------------------------------------------------
	// Design ends, register stand-in and checker
	// ----------------------------------------------------------------
	always #5 clk = ~clk;
	initial begin
		if2.cs_n = 1'b1;
		if2.sclk = 1'b0;
		if2.mosi = 1'b0;
	end
	// Register contents follow the selector so a wrong pick shows in the reply
	function automatic logic [15:0] resp(input logic [4:0] s);
		return {3'b101, s, 8'hC3};
	endfunction : resp
	function automatic logic [7:0] st(input logic [7:0] f, input logic np, input logic pe);
		logic [7:0] s;
		s = {1'b0, f[7], |f[6:5], np, |f[4:2], f[1], f[0], pe};
		s[7] = |{s[6:5], s[3:0]} | ~np;
		return s;
	endfunction : st
	dsf_master i_dsf_master (.clock_i(clk), .srst_i(srst), .spi(if1.master), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
	dsf_device #(.FILT_CYC(20)) i_dsf_device (.clock_i(clk), .srst_i(srst), .spi(if1.device),
		.fail_safe_i(flt[7]), .thermal_warning_i(flt[6]), .thermal_shutdown_i(flt[5]),
		.supply_uv_i(flt[4]), .supply_ov_i(flt[3]), .cp_uv_i(flt[2]), .vds_error_i(flt[1]),
		.overcurrent_i(flt[0]), .sel_addr_o(sel1), .sel_data_i(resp(sel1)), .wr_stb_o(stb1),
		.wr_addr_o(wa), .wr_data_o(wd), .wr_op_clear_o(wclr));
	dsf_device #(.FILT_CYC(20)) i_dsf_device_b (.clock_i(clk), .srst_i(srst), .spi(if2.device),
		.fail_safe_i(flt[7]), .thermal_warning_i(flt[6]), .thermal_shutdown_i(flt[5]),
		.supply_uv_i(flt[4]), .supply_ov_i(flt[3]), .cp_uv_i(flt[2]), .vds_error_i(flt[1]),
		.overcurrent_i(flt[0]), .sel_addr_o(sel2), .sel_data_i(resp(sel2)), .wr_stb_o(stb2),
		.wr_addr_o(), .wr_data_o(), .wr_op_clear_o());
	dsf_link_chk i_dsf_link_chk (.clock_i(clk), .srst_i(srst), .cs_n(if1.cs_n),
		.sclk(if1.sclk), .mosi(if1.mosi), .miso_out(if1.miso_out), .miso_oe_n(if1.miso_oe_n));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic close_out();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic xfer(input logic [23:0] w, output logic [31:0] r);
		logic [31:0] s;
		logic        er;
		apb(1'b1, OFS_TX, {8'h00, w}, s, er);
		do begin
			apb(1'b0, OFS_STAT, '0, s, er);
		end while (s[STAT_BUSY_POS] !== 1'b0);
		q = s;  // Last status word, kept for the flag preview check
		apb(1'b0, OFS_RX, '0, r, er);
	endtask : xfer
	// Bench-made frame: 160 ns link clock, data changed on rises, reply read before falls
	task automatic raw(input int nb, input logic [31:0] w, output logic [24:0] r);
		r = '0;
		@(posedge clk);
		if2.cs_n <= 1'b0;
		if2.mosi <= w[31];
		repeat (8) @(posedge clk);
		r[24] = if2.miso;
		for (int i = 0; i < nb; i++) begin
			if2.sclk <= 1'b1;
			if2.mosi <= w[31-i];
			repeat (8) @(posedge clk);
			if (i < 24) r[23-i] = if2.miso;
			if2.sclk <= 1'b0;
			repeat (8) @(posedge clk);
		end
		if2.cs_n <= 1'b1;
		if2.mosi <= ~if2.mosi;  // Released line must not keep the last bit
		repeat (8) @(posedge clk);
	endtask : raw

	// ----------------------------------------------------------------
	// Monitors and timeout
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (stb1 === 1'b1) begin
			n_stb1++;
			chk("commit while selected", 32'h1, {31'h0, if1.cs_n});
		end
		if (stb2 === 1'b1) n_stb2++;
		if (cyc == 40000) begin
			n_mismatch++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			flt <= rows[i].flt;
			n0 = n_stb1;
			xfer(rows[i].tx, rx);
			chk("reply", {8'h00, st(rows[i].flt, rows[i].power_on_reset_negated_bit, 1'b0),
				resp(rows[i].tx[21:17])}, rx);
			chk("commit count", {31'h0, rows[i].tx[16]}, 32'(n_stb1 - n0));
			chk("flag preview", {31'h0, (|rows[i].flt) | ~rows[i].power_on_reset_negated_bit},
				{31'h0, q[STAT_GEF_POS]});
			if (rows[i].tx[16]) chk("commit word", {10'h000, 1'b1, rows[i].tx[21:17],
				rows[i].tx[15:0]}, {10'h000, wclr, wa, wd});
		end
		// Short thermal pulse is filtered, held levels are reported and released
		flt <= 8'h40;
		repeat (10) @(posedge clk);
		flt <= 8'h00;
		repeat (40) @(posedge clk);
		xfer(24'hC60000, rx);
		chk("short pulse", {8'h00, 8'h10, resp(5'h03)}, rx);
		flt <= 8'h40;
		repeat (60) @(posedge clk);
		xfer(24'hC60000, rx);
		chk("warning", {8'h00, 8'hB0, resp(5'h03)}, rx);
		flt <= 8'h20;
		repeat (60) @(posedge clk);
		xfer(24'hC60000, rx);
		chk("shutdown", {8'h00, 8'hB0, resp(5'h03)}, rx);
		flt <= 8'h00;
		repeat (60) @(posedge clk);
		xfer(24'hC60000, rx);
		chk("thermal release", {8'h00, 8'h10, resp(5'h03)}, rx);
		// Faulty frames and one good write on the second link, each followed by a clean read
		for (int i = 0; i < 7; i++) begin
			n0 = n_stb2;
			raw(raws[i].nb, raws[i].w, r2);
			if (raws[i].nb == 0) chk("zero clock flag", 32'h1, {31'h0, r2[24]});
			chk("frame commit", {31'h0, raws[i].stb}, 32'(n_stb2 - n0));
			raw(24, 32'hC6000000, r2);
			chk("status after frame", {7'h00, 1'b1, st(8'h00, 1'b0, raws[i].pe), resp(5'h03)},
				{7'h00, r2});
		end
		// Reset in mid-run brings the reset bit and the flag back
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		xfer(24'hC60000, rx);
		chk("status after reset", {8'h00, 8'h80, resp(5'h03)}, rx);
		chk("flag preview after reset", 32'h00000002, q);
		apb(1'b0, 12'h00C, '0, q, e);
		chk("unmapped access error", 32'h1, {31'h0, e});
		close_out();
	end
endmodule : driver_spi_slave_frame_tb
